// >>> rtl/pmt_defs.vh
`ifndef PMT_DEFS_VH
`define PMT_DEFS_VH

// ============================================================
// Register byte offsets (Wishbone word aligned)
`define PMT_ADDR_W        4
`define PMT_OFS_COUNT     4'h0
`define PMT_OFS_PERIOD    4'h4
`define PMT_OFS_CTRL      4'h8
`define PMT_OFS_STATUS    4'hc

// ============================================================
// Reset values
`define PMT_RST_COUNT     8'h00
`define PMT_RST_PERIOD    8'hff
`define PMT_RST_CTRL      7'h00
`define PMT_ZERO8         8'h00
`define PMT_ZERO32        32'h0000_0000
`define PMT_RST_ICLK      2'b00

// ============================================================
// Control register fields
`define PMT_CTRL_W        7
`define PMT_RUN_BIT       2
`define PMT_PRE_LSB       0
`define PMT_PRE_MSB       1
`define PMT_POST_LSB      3
`define PMT_POST_MSB      6

// ============================================================
// Prescale codes and terminal counts
`define PMT_PRE_DIV1      2'b00
`define PMT_PRE_DIV4      2'b01
`define PMT_PRE_TC1       4'h0
`define PMT_PRE_TC4       4'h3
`define PMT_PRE_TC16      4'hf

// ============================================================
// Instruction clock: system clock divided by four
`define PMT_ICLK_TC       2'b11

// ============================================================
// Status/mask bit
`define PMT_IRQ_BIT       0
`define PMT_MASK_BIT      8
`define PMT_MASK_LANE     1

// ============================================================
// Register indices in the select vector
`define PMT_NREGS         4
`define PMT_IDX_COUNT     0
`define PMT_IDX_PERIOD    1
`define PMT_IDX_CTRL      2
`define PMT_IDX_STATUS    3

`endif

// >>> rtl/pmt_prescaler.v
`timescale 1ns/1ps
`include "pmt_defs.vh"

module pmt_prescaler (
    // Clock and synchronous clear
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire       clr_i,
    // Control
    input  wire       tick_i,
    input  wire [1:0] sel_i,
    // Output pulse
    output wire       pulse_o
);

    reg  [3:0] cnt_r;
    reg  [3:0] tc;

    always @* begin
        case (sel_i)
            `PMT_PRE_DIV1: tc = `PMT_PRE_TC1;
            `PMT_PRE_DIV4: tc = `PMT_PRE_TC4;
            default:       tc = `PMT_PRE_TC16;
        endcase
    end

    assign pulse_o = tick_i && (cnt_r == tc);

    always @(posedge clk_i) begin
        if (rst_i || clr_i) begin
            cnt_r <= `PMT_PRE_TC1;
        end else if (pulse_o) begin
            cnt_r <= `PMT_PRE_TC1;
        end else if (tick_i) begin
            cnt_r <= cnt_r + 4'h1;
        end
    end

endmodule // pmt_prescaler

// >>> rtl/pmt_postscaler.v
`timescale 1ns/1ps
`include "pmt_defs.vh"

module pmt_postscaler (
    // Clock and synchronous clear
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire       clr_i,
    // Match input and ratio
    input  wire       match_i,
    input  wire [3:0] sel_i,
    // Output pulse
    output wire       pulse_o
);

    reg  [3:0] cnt_r;

    // Ratio is field value plus one
    assign pulse_o = match_i && (cnt_r == sel_i);

    always @(posedge clk_i) begin
        if (rst_i || clr_i) begin
            cnt_r <= 4'h0;
        end else if (pulse_o) begin
            cnt_r <= 4'h0;
        end else if (match_i) begin
            cnt_r <= cnt_r + 4'h1;
        end
    end

endmodule // pmt_postscaler

// >>> rtl/pmt_timer.v
// Design decisions made here: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "pmt_defs.vh"

// Notes on behaviour
// - Separate 8-bit count and period registers
// - Counts from instruction clock, clock divided four
// - Prescaler divides by 1, 4 or 16
// - Count up from zero until period match
// - Match loads zero on next increment
// - Each match advances 1..16 postscaler
// - Postscaler output sets interrupt flag
// - Count and period readable, writable anytime
// - Reset: count zero, period all ones
// - Runs only while run enable set
// - Control fields select pre and post ratios
// - Count/control writes and reset clear pre/postscalers
// - Control write keeps count value
module pmt_timer (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone classic slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output wire        wb_err_o,
    // Interrupt
    output wire        irq_o
);

    // ============================================================
    // Registers
    reg  [7:0]             timer_count_r;
    reg  [7:0]             timer_period_r;
    reg  [`PMT_CTRL_W-1:0] timer_control_reg_r;
    reg                    period_match_irq_flag_r;
    reg                    irq_mask_r;
    reg  [1:0]             iclk_div_r;

    wire                   timer_run_enable;
    wire [1:0]             prescale_select;
    wire [3:0]             postscale_select;

    assign timer_run_enable = timer_control_reg_r[`PMT_RUN_BIT];
    assign prescale_select  =
        timer_control_reg_r[`PMT_PRE_MSB:`PMT_PRE_LSB];
    assign postscale_select =
        timer_control_reg_r[`PMT_POST_MSB:`PMT_POST_LSB];

    // ============================================================
    // Bus decode
    function is_reg;
        input [3:0] adr;
        input [3:0] ofs;
        begin
            is_reg = (adr == ofs);
        end
    endfunction

    // Offset of each register, by its place in reg_hit
    function [3:0] reg_ofs;
        input integer idx;
        begin
            case (idx)
                `PMT_IDX_COUNT:  reg_ofs = `PMT_OFS_COUNT;
                `PMT_IDX_PERIOD: reg_ofs = `PMT_OFS_PERIOD;
                `PMT_IDX_CTRL:   reg_ofs = `PMT_OFS_CTRL;
                default:         reg_ofs = `PMT_OFS_STATUS;
            endcase
        end
    endfunction

    wire [`PMT_NREGS-1:0] reg_hit;
    wire bus_req;
    wire bus_wr;
    wire wr_lane0;
    wire mapped;
    wire wr_count;
    wire wr_period;
    wire wr_ctrl;
    wire wr_status;
    wire wr_mask;

    // Single-cycle answer; ack gap prevents a double take
    assign bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr    = bus_req && wb_we_i;
    assign wr_lane0  = bus_wr && wb_sel_i[0];
    genvar g;
    generate
        for (g = 0; g < `PMT_NREGS; g = g + 1) begin : g_hit
            assign reg_hit[g] = is_reg(wb_adr_i, reg_ofs(g));
        end
    endgenerate

    assign mapped    = |reg_hit;
    assign wr_count  = wr_lane0 && reg_hit[`PMT_IDX_COUNT];
    assign wr_period = wr_lane0 && reg_hit[`PMT_IDX_PERIOD];
    assign wr_ctrl   = wr_lane0 && reg_hit[`PMT_IDX_CTRL];
    // Status: byte 0 is the flag (W1C), byte 1 holds the mask
    assign wr_status = wr_lane0 && reg_hit[`PMT_IDX_STATUS];
    assign wr_mask   = bus_wr && wb_sel_i[`PMT_MASK_LANE]
                    && reg_hit[`PMT_IDX_STATUS];
    assign wb_err_o  = 1'b0;

    // ============================================================
    // Read data
    reg  [31:0] rd_word;

    // Unmapped offsets and unused bits read as zero
    always @* begin
        rd_word = `PMT_ZERO32;
        if (reg_hit[`PMT_IDX_COUNT])
            rd_word[7:0] = timer_count_r;
        else if (reg_hit[`PMT_IDX_PERIOD])
            rd_word[7:0] = timer_period_r;
        else if (reg_hit[`PMT_IDX_CTRL])
            rd_word[`PMT_CTRL_W-1:0] = timer_control_reg_r;
        else if (mapped) begin
            rd_word[`PMT_IRQ_BIT]  = period_match_irq_flag_r;
            rd_word[`PMT_MASK_BIT] = irq_mask_r;
        end
    end

    // ============================================================
    // Bus response
    reg         wb_ack_nxt;
    reg  [31:0] wb_dat_nxt;

    // Read data holds until the next read is taken
    always @* begin
        wb_ack_nxt = bus_req;
        wb_dat_nxt = wb_dat_o;
        if (bus_req && !wb_we_i)
            wb_dat_nxt = rd_word;
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= `PMT_ZERO32;
        end else begin
            wb_ack_o <= wb_ack_nxt;
            wb_dat_o <= wb_dat_nxt;
        end
    end

    // ============================================================
    // Instruction clock enable: one tick per four clocks
    reg  [1:0] iclk_div_nxt;
    wire       iclk_tick;

    assign iclk_tick = (iclk_div_r == `PMT_ICLK_TC);

    // Free running: a restart may land anywhere within a tick
    always @* begin
        iclk_div_nxt = iclk_div_r + 2'b01;
    end

    always @(posedge clk_i) begin
        if (rst_i)
            iclk_div_r <= `PMT_RST_ICLK;
        else
            iclk_div_r <= iclk_div_nxt;
    end

    // ============================================================
    // Prescaler and postscaler
    wire scaler_clr;
    wire pre_pulse;
    wire match;
    wire post_pulse;

    assign scaler_clr = wr_count || wr_ctrl;
    // Stopped timer holds prescaler as well
    wire run_tick;
    assign run_tick = iclk_tick && timer_run_enable;

    pmt_prescaler u_pre (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .clr_i   (scaler_clr),
        .tick_i  (run_tick),
        .sel_i   (prescale_select),
        .pulse_o (pre_pulse)
    );

    // Match counted on the wrapping increment
    wire period_hit;
    assign period_hit = (timer_count_r == timer_period_r);
    assign match      = pre_pulse && period_hit;

    pmt_postscaler u_post (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .clr_i   (scaler_clr),
        .match_i (match),
        .sel_i   (postscale_select),
        .pulse_o (post_pulse)
    );

    // ============================================================
    // Counter and period
    reg  [7:0] timer_count_nxt;
    reg  [7:0] timer_period_nxt;
    wire [7:0] count_inc;

    assign count_inc = timer_count_r + 8'h01;

    // Count write beats a match in the same cycle
    always @* begin
        timer_count_nxt = timer_count_r;
        if (wr_count)
            timer_count_nxt = wb_dat_i[7:0];
        else if (match)
            timer_count_nxt = `PMT_ZERO8;
        else if (pre_pulse)
            timer_count_nxt = count_inc;
    end

    always @* begin
        timer_period_nxt = timer_period_r;
        if (wr_period)
            timer_period_nxt = wb_dat_i[7:0];
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            timer_count_r  <= `PMT_RST_COUNT;
            timer_period_r <= `PMT_RST_PERIOD;
        end else begin
            timer_count_r  <= timer_count_nxt;
            timer_period_r <= timer_period_nxt;
        end
    end

    // ============================================================
    // Control
    reg  [`PMT_CTRL_W-1:0] timer_control_reg_nxt;

    // Control write does not touch the count
    always @* begin
        timer_control_reg_nxt = timer_control_reg_r;
        if (wr_ctrl)
            timer_control_reg_nxt = wb_dat_i[`PMT_CTRL_W-1:0];
    end

    always @(posedge clk_i) begin
        if (rst_i)
            timer_control_reg_r <= `PMT_RST_CTRL;
        else
            timer_control_reg_r <= timer_control_reg_nxt;
    end

    // ============================================================
    // Interrupt flag and mask
    reg  period_match_irq_flag_nxt;
    reg  irq_mask_nxt;
    wire flag_clr;

    assign flag_clr = wr_status && wb_dat_i[`PMT_IRQ_BIT];

    // Set beats write-one-to-clear, so no event is lost
    always @* begin
        period_match_irq_flag_nxt = period_match_irq_flag_r;
        if (post_pulse)
            period_match_irq_flag_nxt = 1'b1;
        else if (flag_clr)
            period_match_irq_flag_nxt = 1'b0;
    end

    always @* begin
        irq_mask_nxt = irq_mask_r;
        if (wr_mask)
            irq_mask_nxt = wb_dat_i[`PMT_MASK_BIT];
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            period_match_irq_flag_r <= 1'b0;
            irq_mask_r              <= 1'b0;
        end else begin
            period_match_irq_flag_r <= period_match_irq_flag_nxt;
            irq_mask_r              <= irq_mask_nxt;
        end
    end

    // Level output: drops as soon as flag or mask clears
    assign irq_o = period_match_irq_flag_r && irq_mask_r;

endmodule // pmt_timer

// >>> test/pmt_timer_assertions.sv
`timescale 1ns/1ps
module pmt_timer_chk (
    input wire        clk_i,
    input wire        rst_i,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [3:0]  wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire        wb_err_o,
    input wire        irq_o
);
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire st_wr = req && wb_we_i && wb_adr_i == 4'hc;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==========
    // Bus
    a_ack_follows: assert property (req |=> wb_ack_o) else $error("no ack");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(req))
        else $error("ack unasked");
    a_err_low: assert property (!wb_err_o) else $error("err seen");
    a_reset_quiet: assert property (disable iff (1'b0)
        rst_i |=> !wb_ack_o && !irq_o && wb_dat_o == 32'h0000_0000)
        else $error("outputs busy after reset");
    a_hi_zero: assert property (wb_dat_o[31:9] == 23'h0) else $error("hi bits");
    a_gap_read: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 4'h2
        |-> wb_dat_o == 32'h0000_0000) else $error("gap read");
    // ==========
    // Interrupt
    a_mask_off: assert property (st_wr && wb_sel_i[1] && !wb_dat_i[8]
        |=> !irq_o) else $error("mask ignored");
    a_flag_sticky: assert property (irq_o && !st_wr |=> irq_o)
        else $error("irq dropped");
    cover property (st_wr);
    cover property ($rose(irq_o));
    cover property (wb_ack_o && !wb_we_i);
    cover property (req && wb_we_i && !wb_sel_i[0]);
endmodule // pmt_timer_chk

// >>> test/tb_period_match_timer_8bit.sv
`timescale 1ns/1ps
`include "pmt_defs.vh"
module tb_period_match_timer_8bit;
    logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
    logic [3:0]  adr = 4'h0, sel = 4'hf, post;
    logic [31:0] dat = 32'h0000_0000, dat_o, rd, d;
    logic [7:0]  p, c1;
    logic [1:0]  pre;
    logic        ack, err, irq;
    int          err_total = 0, check_count = 0, n;
    pmt_timer i_pmt_timer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err),
        .irq_o(irq));
    // ==========
    // Helpers
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %0t seen %h exp %h", $time, s, e);
        end
    endtask
    // Ack sampled before this edge's updates land
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] v);
        int k;
        k = 0;
        @(posedge clk_i);
        cyc <= 1;
        stb <= 1;
        we  <= w;
        adr <= a;
        dat <= v;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 50);
        if (ack !== 1'b1) err_total++;
        rd = dat_o;
        cyc <= 0;
        stb <= 0;
    endtask
    function automatic int exp_clks(logic [1:0] r, logic [7:0] q,
                                    logic [3:0] s);
        return 4 * (r == 0 ? 1 : r == 1 ? 4 : 16) * (q + 1) * (s + 1);
    endfunction
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ==========
    // Clock, watchdog
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    initial begin
        repeat (60000) @(posedge clk_i);
        err_total++;
        close_out;
    end
    // ==========
    // Tests
    initial begin
        n = $urandom(10042);
        repeat (10) @(posedge clk_i);
        rst_i <= 0;
        bus(0, `PMT_OFS_COUNT, 0); chk(rd, 32'h0000_0000);
        bus(0, `PMT_OFS_PERIOD, 0); chk(rd, 32'h0000_00ff);
        bus(0, 4'h2, 0); chk(rd, 32'h0000_0000);
        // Writes on unselected byte lanes must be ignored
        sel <= 4'he;
        bus(1, `PMT_OFS_COUNT, 32'h0000_005a);
        sel <= 4'h1;
        bus(1, `PMT_OFS_STATUS, 32'h0000_0100);
        sel <= 4'hf;
        bus(0, `PMT_OFS_COUNT, 0); chk(rd, 32'h0000_0000);
        bus(0, `PMT_OFS_STATUS, 0); chk(rd, 32'h0000_0000);
        for (int i = 0; i < 2; i++) begin
            d = $urandom;
            bus(1, i ? `PMT_OFS_PERIOD : `PMT_OFS_COUNT, d);
            bus(0, i ? `PMT_OFS_PERIOD : `PMT_OFS_COUNT, 0);
            chk(rd, {24'h00_0000, d[7:0]});
        end
        $display("register test done");
        for (int c = 0; c < 5; c++) begin
            pre = c[1:0];
            p = 8'($urandom_range(7));
            post = 4'($urandom_range(3));
            if (c == 4) begin
                pre = 0; p = 0; post = 4'hf;
            end
            bus(1, `PMT_OFS_CTRL, 0);
            bus(1, `PMT_OFS_COUNT, 0);
            bus(1, `PMT_OFS_PERIOD, {24'h00_0000, p});
            bus(1, `PMT_OFS_STATUS, 32'h0000_0101);
            bus(1, `PMT_OFS_CTRL, {25'h0, post, 1'b1, pre});
            n = 0;
            while (irq !== 1'b1 && n < 20000) begin
                @(posedge clk_i);
                n++;
            end
            chk(n >= exp_clks(pre, p, post) - 8 &&
                n <= exp_clks(pre, p, post) + 8, 1);
            bus(0, `PMT_OFS_STATUS, 0); chk(rd[0], 1);
            bus(1, `PMT_OFS_CTRL, 0);
            bus(0, `PMT_OFS_COUNT, 0); c1 = rd[7:0];
            // Long period and 1:1 so a run leak would move the count
            bus(1, `PMT_OFS_PERIOD, 32'h0000_00ff);
            bus(1, `PMT_OFS_CTRL, 32'h0000_0078);
            repeat (40) @(posedge clk_i);
            bus(0, `PMT_OFS_COUNT, 0); chk(rd[7:0], c1);
            bus(1, `PMT_OFS_STATUS, 0); chk(irq, 0);
            bus(1, `PMT_OFS_STATUS, 32'h0000_0100); chk(irq, 1);
            bus(1, `PMT_OFS_STATUS, 32'h0000_0101); chk(irq, 0);
            bus(0, `PMT_OFS_STATUS, 0); chk(rd, 32'h0000_0100);
            $display("timing case %0d done", c);
        end
        close_out;
    end
endmodule // tb_period_match_timer_8bit

bind pmt_timer pmt_timer_chk i_pmt_timer_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .irq_o(irq_o));
